// *** cwo_regs.sv ***
// Purpose: Sprite origin and window corner registers with retrace commit
// Assumes: vblank comes from display timing on pclk; APB4 slave, 8-bit
//          registers in the low byte of each word
// Notes:   Staged values reach the display side at the start of vblank
//
// Behaviour
// - Origin gives sprite 64x64 area offset from cross-hair point.
// - Each origin register holds six bits, values 0 to 63.
// - Both origin registers reset to 31.
// - Origin bits 7 and 6 read back zero.
// - New origin reaches display only at next vertical retrace.
// - Start corner is upper-left bound of cursor or auxiliary window.
// - Start coordinate is 12 bits from low and high byte registers.
// - Start high byte registers read zero in bits 7 to 4.
// - Start corner commits at retrace after start y high write.
// - Window registers have no defined value until written.
// - Start coordinate is inclusive, first pixel inside window.
// - Stop coordinate is inclusive, last pixel inside window.
// - Coordinates are relative to first displayed pixel (0,0).
// - Stop coordinate is 12 bits from low and high byte registers.
// - Stop high byte registers read zero in bits 7 to 4.
// - Stop corner commits at retrace after stop y high write.
// - Every register is readable and writable at any time.

`timescale 1ns/10ps

module cwo_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              vblank,
    input  wire cwo_pkg::cwo_corner_t cursor,
    input  wire cwo_pkg::cwo_corner_t pixel,
    output cwo_pkg::cwo_origin_t   origin,
    output cwo_pkg::cwo_corner_t   win_begin,
    output cwo_pkg::cwo_corner_t   win_end,
    output logic                   begin_valid,
    output logic                   end_valid,
    output logic                   in_window,
    output logic                   in_sprite
);

    function automatic logic hit(
        input logic [ADDR_W-1:0]          a,
        input logic [cwo_pkg::IDX_W-1:0]  idx
    );
        hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic in_span(
        input logic [cwo_pkg::COORD_W-1:0] p,
        input logic [cwo_pkg::COORD_W-1:0] lo,
        input logic [cwo_pkg::COORD_W-1:0] hi
    );
        in_span = (p >= lo) && (p <= hi);
    endfunction

    // Staging side, host view
    cwo_pkg::cwo_origin_t org_s;
    cwo_pkg::cwo_corner_t beg_s;
    cwo_pkg::cwo_corner_t end_s;
    logic                 org_pend;
    logic                 beg_pend;
    logic                 end_pend;
    logic                 vblank_q;

    wire logic setup_ph = psel & ~penable;
    wire logic access   = psel & penable;
    wire logic wr_en    = access & pwrite & pstrb[0];

    wire logic h_org_x  = hit(paddr, cwo_pkg::IDX_ORG_X);
    wire logic h_org_y  = hit(paddr, cwo_pkg::IDX_ORG_Y);
    wire logic h_bxl    = hit(paddr, cwo_pkg::IDX_BEG_X_LOW);
    wire logic h_bxh    = hit(paddr, cwo_pkg::IDX_BEG_X_HIGH);
    wire logic h_exl    = hit(paddr, cwo_pkg::IDX_END_X_LOW);
    wire logic h_exh    = hit(paddr, cwo_pkg::IDX_END_X_HIGH);
    wire logic h_byl    = hit(paddr, cwo_pkg::IDX_BEG_Y_LOW);
    wire logic h_byh    = hit(paddr, cwo_pkg::IDX_BEG_Y_HIGH);
    wire logic h_eyl    = hit(paddr, cwo_pkg::IDX_END_Y_LOW);
    wire logic h_eyh    = hit(paddr, cwo_pkg::IDX_END_Y_HIGH);

    wire logic mapped   = h_org_x | h_org_y | h_bxl | h_bxh | h_exl
                        | h_exh | h_byl | h_byh | h_eyl | h_eyh;

    // Zero wait states; no access gate tied to display state
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    wire logic vb_start = vblank & ~vblank_q;

    wire logic org_trig = wr_en & (h_org_x | h_org_y);
    wire logic beg_trig = wr_en & h_byh;
    wire logic end_trig = wr_en & h_eyh;

    // A trigger in the commit cycle is kept for the next retrace
    wire logic next_org_pend = org_trig | (org_pend & ~vb_start);
    wire logic next_beg_pend = beg_trig | (beg_pend & ~vb_start);
    wire logic next_end_pend = end_trig | (end_pend & ~vb_start);

    wire logic org_commit = vb_start & org_pend;
    wire logic beg_commit = vb_start & beg_pend;
    wire logic end_commit = vb_start & end_pend;

    // Read data, unused upper bits forced low
    wire logic [7:0] rd_org_x = {2'h0, org_s.x};
    wire logic [7:0] rd_org_y = {2'h0, org_s.y};
    wire logic [7:0] rd_bxh   = {4'h0, beg_s.x[11:8]};
    wire logic [7:0] rd_byh   = {4'h0, beg_s.y[11:8]};
    wire logic [7:0] rd_exh   = {4'h0, end_s.x[11:8]};
    wire logic [7:0] rd_eyh   = {4'h0, end_s.y[11:8]};

    wire logic [7:0] rd_byte =
        h_org_x ? rd_org_x :
        h_org_y ? rd_org_y :
        h_bxl   ? beg_s.x[7:0] :
        h_bxh   ? rd_bxh :
        h_byl   ? beg_s.y[7:0] :
        h_byh   ? rd_byh :
        h_exl   ? end_s.x[7:0] :
        h_exh   ? rd_exh :
        h_eyl   ? end_s.y[7:0] :
        h_eyh   ? rd_eyh : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup_ph && !pwrite)
            prdata <= {24'h00_0000, rd_byte};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            org_s.x <= cwo_pkg::ORG_RST;
            org_s.y <= cwo_pkg::ORG_RST;
        end
        else
        begin
            if (wr_en && h_org_x)
                org_s.x <= pwdata[cwo_pkg::ORG_MSB:0];
            if (wr_en && h_org_y)
                org_s.y <= pwdata[cwo_pkg::ORG_MSB:0];
        end
    end

    // Window staging: zero here, but software must not rely on it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            beg_s <= {cwo_pkg::COORD_RST, cwo_pkg::COORD_RST};
            end_s <= {cwo_pkg::COORD_RST, cwo_pkg::COORD_RST};
        end
        else if (wr_en)
        begin
            // High nibble kept only, so codes stay within 0..4095
            if (h_bxl) beg_s.x[7:0]  <= pwdata[cwo_pkg::LOW_MSB:0];
            if (h_bxh) beg_s.x[11:8] <= pwdata[cwo_pkg::HIGH_MSB:0];
            if (h_byl) beg_s.y[7:0]  <= pwdata[cwo_pkg::LOW_MSB:0];
            if (h_byh) beg_s.y[11:8] <= pwdata[cwo_pkg::HIGH_MSB:0];
            if (h_exl) end_s.x[7:0]  <= pwdata[cwo_pkg::LOW_MSB:0];
            if (h_exh) end_s.x[11:8] <= pwdata[cwo_pkg::HIGH_MSB:0];
            if (h_eyl) end_s.y[7:0]  <= pwdata[cwo_pkg::LOW_MSB:0];
            if (h_eyh) end_s.y[11:8] <= pwdata[cwo_pkg::HIGH_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vblank_q <= 1'b0;
            org_pend <= 1'b0;
            beg_pend <= 1'b0;
            end_pend <= 1'b0;
        end
        else
        begin
            vblank_q <= vblank;
            org_pend <= next_org_pend;
            beg_pend <= next_beg_pend;
            end_pend <= next_end_pend;
        end
    end

    // Display side copies
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            origin.x    <= cwo_pkg::ORG_RST;
            origin.y    <= cwo_pkg::ORG_RST;
            win_begin   <= {cwo_pkg::COORD_RST, cwo_pkg::COORD_RST};
            win_end     <= {cwo_pkg::COORD_RST, cwo_pkg::COORD_RST};
            begin_valid <= 1'b0;
            end_valid   <= 1'b0;
        end
        else
        begin
            if (org_commit)
                origin <= org_s;
            if (beg_commit)
                win_begin <= beg_s;
            if (end_commit)
                win_end <= end_s;
            begin_valid <= begin_valid | beg_commit;
            end_valid   <= end_valid | end_commit;
        end
    end

    // Pixel and cursor share the screen frame whose origin is (0,0)
    wire logic win_hit = in_span(pixel.x, win_begin.x, win_end.x)
                       & in_span(pixel.y, win_begin.y, win_end.y);

    // Sprite area top-left is cursor point minus origin; wraps at 4096
    wire logic [cwo_pkg::COORD_W-1:0] spr_left =
        cursor.x - {{(cwo_pkg::COORD_W-cwo_pkg::ORG_W){1'b0}}, origin.x};
    wire logic [cwo_pkg::COORD_W-1:0] spr_top  =
        cursor.y - {{(cwo_pkg::COORD_W-cwo_pkg::ORG_W){1'b0}}, origin.y};
    wire logic [cwo_pkg::COORD_W-1:0] spr_dx = pixel.x - spr_left;
    wire logic [cwo_pkg::COORD_W-1:0] spr_dy = pixel.y - spr_top;
    wire logic spr_hit =
        (spr_dx[cwo_pkg::COORD_W-1:cwo_pkg::SPRITE_LOG2] == '0)
      & (spr_dy[cwo_pkg::COORD_W-1:cwo_pkg::SPRITE_LOG2] == '0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_window <= 1'b0;
            in_sprite <= 1'b0;
        end
        else
        begin
            // Window hidden until both corners have been committed
            in_window <= win_hit & begin_valid & end_valid;
            in_sprite <= spr_hit;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_org_read_top: assert property (
        access && !pwrite && (h_org_x || h_org_y) |-> prdata[7:6] == 2'h0)
        else $error("origin read shows upper bits set");

    a_beg_high_read: assert property (
        access && !pwrite && (h_bxh || h_byh) |-> prdata[7:4] == 4'h0)
        else $error("start high byte read shows upper bits set");

    a_end_high_read: assert property (
        access && !pwrite && (h_exh || h_eyh) |-> prdata[7:4] == 4'h0)
        else $error("stop high byte read shows upper bits set");

    a_org_after_rst: assert property (
        $rose(presetn) |-> origin.x == 6'h1F && origin.y == 6'h1F)
        else $error("origin not 31 after reset");

    a_org_only_vb: assert property (
        $changed(origin) |-> $past(vb_start) && $past(org_pend))
        else $error("origin changed outside retrace commit");

    a_beg_commit: assert property (
        vb_start && beg_pend |=>
        win_begin == $past(beg_s) && beg_pend == $past(beg_trig))
        else $error("start corner not committed at retrace");

    a_end_only_vb: assert property (
        $changed(win_end) |-> $past(vb_start) && $past(end_pend))
        else $error("stop corner changed outside retrace commit");

    a_trig_kept: assert property (
        vb_start && (org_trig || beg_trig) |=>
        (org_pend || !$past(org_trig)) && (beg_pend || !$past(beg_trig)))
        else $error("trigger lost in commit cycle");

    a_beg_packing: assert property (
        wr_en && h_bxh |=> beg_s.x[11:8] == $past(pwdata[3:0]))
        else $error("start x high nibble not stored");

    a_window_incl: assert property (
        begin_valid && end_valid && $stable(win_begin) && $stable(win_end)
        && pixel == win_begin && in_span(win_begin.x, 12'h000, win_end.x)
        && in_span(win_begin.y, 12'h000, win_end.y) |=> in_window)
        else $error("start corner pixel not inside window");

    // A trigger in the commit cycle must survive for the next retrace
    a_org_commit: assert property (
        vb_start && org_pend |=>
        origin == $past(org_s) && org_pend == $past(org_trig))
        else $error("origin commit lost or copied wrong value");

    a_org_pend_set: assert property (
        org_trig |=> org_pend)
        else $error("origin write did not arm the commit");

    a_org_y_store: assert property (
        wr_en && h_org_y |=> org_s.y == $past(pwdata[5:0]))
        else $error("origin y not stored as six bits");

    a_beg_only_vb: assert property (
        $changed(win_begin) |->
        $past(vb_start) && $past(beg_pend))
        else $error("start corner changed outside retrace commit");

    a_beg_pend_set: assert property (
        beg_trig |=> beg_pend)
        else $error("start y high write did not arm the commit");

    a_beg_y_pack: assert property (
        wr_en && h_byl |=> beg_s.y[7:0] == $past(pwdata[7:0]))
        else $error("start y low byte not stored");

    a_valid_sticky: assert property (
        begin_valid && end_valid |=> begin_valid && end_valid)
        else $error("corner valid flag dropped");

    a_end_commit: assert property (
        vb_start && end_pend |=>
        win_end == $past(end_s) && end_pend == $past(end_trig))
        else $error("stop corner not committed at retrace");

    a_end_pend_set: assert property (
        end_trig |=> end_pend)
        else $error("stop y high write did not arm the commit");

    a_end_y_pack: assert property (
        wr_en && h_eyh |=> end_s.y[11:8] == $past(pwdata[3:0]))
        else $error("stop y high nibble not stored");

    a_rd_upper_zero: assert property (
        access && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above the byte lane not zero");

    a_win_gate: assert property (
        !(begin_valid && end_valid) |=> !in_window)
        else $error("window shown before both corners committed");

    a_win_before_beg: assert property (
        win_begin.x != 12'h000 && pixel.x == win_begin.x - 12'h001
        |=> !in_window)
        else $error("pixel left of start corner shown inside window");

    a_win_past_end: assert property (
        win_end.x != 12'hFFF && pixel.x == win_end.x + 12'h001
        |=> !in_window)
        else $error("pixel right of stop corner shown inside window");

    a_spr_anchor: assert property (
        pixel.x + {6'h00, origin.x} == cursor.x &&
        pixel.y + {6'h00, origin.y} == cursor.y |=> in_sprite)
        else $error("sprite top-left pixel not inside sprite");

    a_spr_far_side: assert property (
        pixel.x - 12'h040 + {6'h00, origin.x} == cursor.x
        |=> !in_sprite)
        else $error("pixel 64 right of sprite edge shown inside");

    c_beg_commit: cover property (vb_start && beg_pend);
    c_trig_on_vb: cover property (vb_start && org_trig);
    c_unmapped:   cover property (pslverr);
    c_in_sprite:  cover property (in_sprite && in_window);
    c_org_commit: cover property (org_commit);

endmodule

// *** cwo_pkg.sv ***
// Purpose: Constants and carrier types for the cursor window origin regs
// Assumes: Register index times four is the APB byte address
// Notes:   Coordinates are 12 bits, sprite origin 6 bits

package cwo_pkg;

    localparam int COORD_W = 12;
    localparam int ORG_W   = 6;
    localparam int IDX_W   = 6;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_ORG_X      = 6'h04;
    localparam logic [IDX_W-1:0] IDX_ORG_Y      = 6'h05;
    localparam logic [IDX_W-1:0] IDX_BEG_X_LOW  = 6'h10;
    localparam logic [IDX_W-1:0] IDX_BEG_X_HIGH = 6'h11;
    localparam logic [IDX_W-1:0] IDX_END_X_LOW  = 6'h12;
    localparam logic [IDX_W-1:0] IDX_END_X_HIGH = 6'h13;
    localparam logic [IDX_W-1:0] IDX_BEG_Y_LOW  = 6'h14;
    localparam logic [IDX_W-1:0] IDX_BEG_Y_HIGH = 6'h15;
    localparam logic [IDX_W-1:0] IDX_END_Y_LOW  = 6'h16;
    localparam logic [IDX_W-1:0] IDX_END_Y_HIGH = 6'h17;

    // Field positions inside the byte registers
    localparam int LOW_MSB  = 7;
    localparam int HIGH_MSB = 3;
    localparam int ORG_MSB  = 5;

    // Values after reset
    localparam logic [ORG_W-1:0]   ORG_RST   = 6'h1F;
    localparam logic [COORD_W-1:0] COORD_RST = 12'h000;

    // Side of the square sprite area, as a shift
    localparam int SPRITE_LOG2 = 6;

    typedef struct packed {
        logic [COORD_W-1:0] x;
        logic [COORD_W-1:0] y;
    } cwo_corner_t;

    typedef struct packed {
        logic [ORG_W-1:0] x;
        logic [ORG_W-1:0] y;
    } cwo_origin_t;

endpackage

// *** cwo_host.sv ***
// Purpose: Host model, APB master reaching the byte-wide registers
// Assumes: Slave answers with pready; only the bench watchdog ends a wait
// Notes:   Signals change only by non-blocking assignment after a rising edge

`timescale 1ns/10ps

module cwo_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb
);
    initial
    begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        pstrb <= 4'hF;
    end

    // Only byte values travel, so each write stays within a byte
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Coordinates kept to 12 bits, low byte first, junk in the top nibble
    task automatic wco(input logic [7:0] a, input logic [11:0] v,
                       input logic [3:0] junk);
        logic [7:0] q;
        logic       e;
        xfer(1'b1, a, v[7:0], q, e);
        xfer(1'b1, a + 8'h04, {junk, v[11:8]}, q, e);
    endtask

    // Strobe changes only between transfers
    task automatic strb(input logic [3:0] s);
        @(posedge pclk);
        pstrb <= s;
    endtask
endmodule

// *** tb_top.sv ***
// Purpose: Self-checking bench for the cursor window origin registers
// Assumes: vblank, cursor and pixel driven on pclk by the bench
// Notes:   Window corners chosen on the active display area

`timescale 1ns/10ps

`define CHK(nm, ex, got) \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
        $display("BAD %s exp %h got %h", nm, ex, got); \
        error_cnt++; \
    end

module tb_top;
    logic                 pclk = 0;
    logic                 presetn = 0;
    logic                 vblank = 0;
    cwo_pkg::cwo_corner_t cursor = '0;
    cwo_pkg::cwo_corner_t pixel = '0;
    cwo_pkg::cwo_origin_t origin;
    cwo_pkg::cwo_corner_t win_begin;
    cwo_pkg::cwo_corner_t win_end;
    logic psel, penable, pwrite, pready, pslverr, begin_valid, end_valid;
    logic in_window, in_sprite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [3:0]  pstrb;
    logic [7:0]  q;
    logic        e;
    int          error_cnt = 0;
    int          n_checks = 0;

    always #5 pclk = ~pclk;

    cwo_host host_u (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    cwo_regs #(.ADDR_W(8)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vblank(vblank), .cursor(cursor),
        .pixel(pixel), .origin(origin), .win_begin(win_begin),
        .win_end(win_end), .begin_valid(begin_valid),
        .end_valid(end_valid), .in_window(in_window),
        .in_sprite(in_sprite));

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic vbl();
        @(posedge pclk);
        vblank <= 1'b1;
        repeat (3) @(posedge pclk);
        vblank <= 1'b0;
        @(posedge pclk);
        #1;
    endtask

    task automatic pix(input logic [11:0] x, input logic [11:0] y,
                       input logic ew, input logic es);
        @(posedge pclk);
        pixel <= {x, y};
        repeat (2) @(posedge pclk);
        #1;
        `CHK("in_window", ew, in_window)
        `CHK("in_sprite", es, in_sprite)
    endtask

    initial
    begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK("origin rst", 12'h7DF, origin)
        host_u.xfer(0, 8'h10, 8'h00, q, e);
        `CHK("org x rst", 8'h1F, q)
        `CHK("mapped err", 1'b0, e)
        host_u.xfer(0, 8'h14, 8'h00, q, e);
        `CHK("org y rst", 8'h1F, q)
        host_u.xfer(1, 8'h10, 8'hFF, q, e);
        host_u.xfer(0, 8'h10, 8'h00, q, e);
        `CHK("org x rd", 8'h3F, q)
        `CHK("origin held", 12'h7DF, origin)
        vbl();
        `CHK("origin x", 12'hFDF, origin)
        // Write during blanking: accepted, commits at the next rise only
        @(posedge pclk);
        vblank <= 1'b1;
        host_u.xfer(1, 8'h14, 8'h00, q, e);
        host_u.xfer(0, 8'h14, 8'h00, q, e);
        `CHK("org y rd", 8'h00, q)
        `CHK("origin y held", 12'hFDF, origin)
        vblank <= 1'b0;
        vbl();
        `CHK("origin y", 12'hFC0, origin)
        host_u.wco(8'h40, 12'h123, 4'hF);
        host_u.xfer(0, 8'h44, 8'h00, q, e);
        `CHK("beg x hi", 8'h01, q)
        vbl();
        `CHK("beg no trig", 1'b0, begin_valid)
        // Start corner placed on the active display
        host_u.wco(8'h50, 12'h045, 4'hA);
        host_u.xfer(0, 8'h54, 8'h00, q, e);
        `CHK("beg y hi", 8'h00, q)
        `CHK("beg wait", 1'b0, begin_valid)
        vbl();
        `CHK("win_begin", 24'h123045, win_begin)
        `CHK("beg valid", 1'b1, begin_valid)
        host_u.wco(8'h48, 12'h1F0, 4'h5);
        host_u.wco(8'h58, 12'h0C8, 4'hC);
        host_u.xfer(0, 8'h5C, 8'h00, q, e);
        `CHK("end y hi", 8'h00, q)
        host_u.xfer(0, 8'h48, 8'h00, q, e);
        `CHK("end x lo", 8'hF0, q)
        vbl();
        `CHK("win_end", 24'h1F00C8, win_end)
        `CHK("end valid", 1'b1, end_valid)
        pix(12'h123, 12'h045, 1, 0);
        pix(12'h1F0, 12'h0C8, 1, 0);
        pix(12'h122, 12'h045, 0, 0);
        pix(12'h1F1, 12'h0C8, 0, 0);
        pix(12'h123, 12'h0C9, 0, 0);
        @(posedge pclk);
        cursor <= {12'h100, 12'h100};
        pix(12'h0C1, 12'h100, 0, 1);
        pix(12'h100, 12'h13F, 0, 1);
        pix(12'h101, 12'h100, 0, 0);
        pix(12'h0C0, 12'h100, 0, 0);
        // Origin write landing on the retrace edge waits one more frame
        host_u.xfer(1, 8'h10, 8'h05, q, e);
        fork
            host_u.xfer(1, 8'h10, 8'h0A, q, e);
            begin
                repeat (2) @(posedge pclk);
                vblank <= 1'b1;
            end
        join
        vblank <= 1'b0;
        #1;
        `CHK("origin old stage", 12'h140, origin)
        vbl();
        `CHK("origin new stage", 12'h280, origin)
        // Low strobe off: write is dropped without error
        host_u.strb(4'hE);
        host_u.xfer(1, 8'h10, 8'h2A, q, e);
        host_u.strb(4'hF);
        host_u.xfer(0, 8'h10, 8'h00, q, e);
        `CHK("strobe off", 8'h0A, q)
        // Reset in mid-run brings the origin back to the centre
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK("origin re-rst", 12'h7DF, origin)
        `CHK("beg valid rst", 1'b0, begin_valid)
        host_u.xfer(0, 8'h14, 8'h00, q, e);
        `CHK("org y re-rst", 8'h1F, q)
        host_u.xfer(0, 8'h18, 8'h00, q, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped rd", 8'h00, q)
        tally_and_finish();
    end
endmodule
